// File: osg_top.sv
// Operation status group: condition, edge filters, latching events, enable and summary
// How it works
// - Condition register mirrors live signals; writes to it are ignored.
// - Rising and falling edge masks are read/write.
// - A passed transition sets its event bit, which stays until cleared.
// - Reading the event register returns it, then clears all bits except those set in the same cycle.
// - Enable register is read/write.
// - OR of group outputs forms summary flag at status byte bit 7.
// - Rising mask passes rising edges; both masks pass any, none pass none.
// - Falling mask passes falling edges.
// - Writing a mask can itself raise an event from the current level.
// - Bits 0 calibration, 5 awaiting trigger, 8 voltage reg, 10 current reg.
`timescale 1ns/1ps
module osg_top
	import osg_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register port
	input wire osg_pkg::osg_req_t req,
	output logic [osg_pkg::OSG_DATA_W-1:0] rdata,
	// Monitored signals from the power module
	input wire osg_pkg::osg_cond_t cond_in,
	// Summary and interrupt
	output logic operation_summary_flag,
	output logic irq
);
	import osg_pkg::*;

	osg_cond_t cond_sync;
	logic [15:0] cond_vec;
	logic [15:0] cond_prev_reg;
	logic [15:0] cond_prev_next;
	logic [15:0] rise_reg;
	logic [15:0] rise_next;
	logic [15:0] fall_reg;
	logic [15:0] fall_next;
	logic [15:0] enable_reg;
	logic [15:0] enable_next;
	logic [15:0] event_reg;
	logic [15:0] event_next;
	logic [15:0] set_vec;
	logic [15:0] rdata_next;
	logic [15:0] status_byte;
	logic rise_wr;
	logic fall_wr;
	logic event_rd;

	// Pins come from another domain
	osg_sync #(.W(4)) u_sync
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.d_in(cond_in),
		.d_out(cond_sync)
	);

	// Condition register is only a view of live inputs
	always_comb
	begin
		cond_vec = 16'h0000;
		cond_vec[OSG_CAL_BIT] = cond_sync.calibrating;
		cond_vec[OSG_TRIG_BIT] = cond_sync.awaiting_trigger_flag;
		cond_vec[OSG_VREG_BIT] = cond_sync.voltage_regulation_flag;
		cond_vec[OSG_IREG_BIT] = cond_sync.current_regulation_flag;
	end

	assign rise_wr = req.wr && (req.addr == OSG_RISE_ADDR);
	assign fall_wr = req.wr && (req.addr == OSG_FALL_ADDR);
	assign event_rd = req.rd && (req.addr == OSG_EVENT_ADDR);

	// Edge detection and filtering, one slice per bit
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_filter
			logic rose;
			logic fell;
			logic newly_rise;
			logic newly_fall;
			assign rose = cond_vec[gi] && !cond_prev_reg[gi];
			assign fell = !cond_vec[gi] && cond_prev_reg[gi];
			// A mask bit going 0->1 while the level already sits there counts as an edge
			assign newly_rise = rise_wr && req.wdata[gi] && !rise_reg[gi] && cond_vec[gi];
			assign newly_fall = fall_wr && req.wdata[gi] && !fall_reg[gi] && !cond_vec[gi];
			assign set_vec[gi] = (rose && rise_reg[gi])
				|| (fell && fall_reg[gi])
				|| newly_rise || newly_fall;
		end
	endgenerate

	always_comb
	begin
		cond_prev_next = cond_vec;
		rise_next = rise_reg;
		fall_next = fall_reg;
		enable_next = enable_reg;
		if (rise_wr)
			rise_next = req.wdata;
		if (fall_wr)
			fall_next = req.wdata;
		if (req.wr && (req.addr == OSG_ENABLE_ADDR))
			enable_next = req.wdata;
		// Clear on read, but a set arriving in the same cycle wins
		event_next = event_rd ? 16'h0000 : event_reg;
		event_next = event_next | (set_vec & OSG_USED_MASK);
	end

	// Summary of enabled latched events
	always_comb
	begin
		operation_summary_flag = |(event_reg & enable_reg);
		status_byte = 16'h0000;
		status_byte[OSG_SUMMARY_BIT] = operation_summary_flag;
		irq = operation_summary_flag;
	end

	// Writes to condition, event and status addresses fall through unused
	always_comb
	begin
		rdata_next = 16'h0000;
		if (req.rd)
		begin
			unique case (req.addr)
				OSG_COND_ADDR: rdata_next = cond_vec;
				OSG_RISE_ADDR: rdata_next = rise_reg;
				OSG_FALL_ADDR: rdata_next = fall_reg;
				OSG_EVENT_ADDR: rdata_next = event_reg;
				OSG_ENABLE_ADDR: rdata_next = enable_reg;
				OSG_STATUS_ADDR: rdata_next = status_byte;
				default: rdata_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cond_prev_reg <= 16'h0000;
			rise_reg <= OSG_RISE_RST;
			fall_reg <= OSG_FALL_RST;
			enable_reg <= OSG_ENABLE_RST;
			event_reg <= OSG_EVENT_RST;
			rdata <= 16'h0000;
		end
		else
		begin
			cond_prev_reg <= cond_prev_next;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
			enable_reg <= enable_next;
			event_reg <= event_next;
			rdata <= rdata_next;
		end
	end

	// Helper: previous-cycle read strobe on event register
	logic ev_rd_d;
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			ev_rd_d <= 1'b0;
		else
			ev_rd_d <= event_rd;
	end

	cond_view_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		req.rd && req.addr == OSG_COND_ADDR |=> rdata == $past(cond_vec))
		else $error("condition read does not match live state");
	rise_rw_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		rise_wr |=> rise_reg == $past(req.wdata))
		else $error("rising mask write lost");
	event_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		event_reg[OSG_VREG_BIT] && !event_rd |=> event_reg[OSG_VREG_BIT])
		else $error("event bit dropped without a read");
	read_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		event_rd && set_vec == 16'h0000 |=> event_reg == 16'h0000 && rdata == $past(event_reg))
		else $error("event read did not clear");
	enable_rw_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		req.wr && req.addr == OSG_ENABLE_ADDR |=> enable_reg == $past(req.wdata))
		else $error("enable write lost");
	summary_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		operation_summary_flag == (|(event_reg & enable_reg)) && irq == operation_summary_flag)
		else $error("summary flag wrong");
	rise_pass_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(cond_vec[OSG_TRIG_BIT]) && rise_reg[OSG_TRIG_BIT] |=> event_reg[OSG_TRIG_BIT])
		else $error("rising edge not latched");
	fall_pass_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$fell(cond_vec[OSG_CAL_BIT]) && fall_reg[OSG_CAL_BIT] |=> event_reg[OSG_CAL_BIT])
		else $error("falling edge not latched");
	no_pass_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!rise_reg[OSG_IREG_BIT] && !fall_reg[OSG_IREG_BIT] && !rise_wr && !fall_wr
		&& !event_reg[OSG_IREG_BIT] |=> !event_reg[OSG_IREG_BIT])
		else $error("masked transition latched");
	mask_event_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		rise_wr && req.wdata[OSG_VREG_BIT] && !rise_reg[OSG_VREG_BIT] && cond_vec[OSG_VREG_BIT]
		|=> event_reg[OSG_VREG_BIT])
		else $error("mask write did not raise event");
	unused_bits_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(event_reg & ~OSG_USED_MASK) == 16'h0000)
		else $error("event on unassigned bit");

	// Mask and enable registers only move on their own write strobe
	fall_rw_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		fall_wr |=> fall_reg == $past(req.wdata))
		else $error("falling mask write lost");
	rise_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!rise_wr |=> $stable(rise_reg))
		else $error("rising mask changed without a write");
	fall_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!fall_wr |=> $stable(fall_reg))
		else $error("falling mask changed without a write");
	enable_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!(req.wr && req.addr == OSG_ENABLE_ADDR) |=> $stable(enable_reg))
		else $error("enable changed without a write");

	// Read port returns the addressed register one cycle after the strobe
	rise_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		req.rd && req.addr == OSG_RISE_ADDR |=> rdata == $past(rise_reg))
		else $error("rising mask read wrong");
	fall_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		req.rd && req.addr == OSG_FALL_ADDR |=> rdata == $past(fall_reg))
		else $error("falling mask read wrong");
	enable_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		req.rd && req.addr == OSG_ENABLE_ADDR |=> rdata == $past(enable_reg))
		else $error("enable read wrong");
	status_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		req.rd && req.addr == OSG_STATUS_ADDR
		|=> rdata[OSG_SUMMARY_BIT] == $past(operation_summary_flag)
		&& (rdata & ~(16'h0001 << OSG_SUMMARY_BIT)) == 16'h0000)
		else $error("status byte read wrong");
	idle_rdata_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!req.rd |=> rdata == 16'h0000)
		else $error("read data without a read strobe");

	// Event latching, edge filtering and clear on read
	event_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(set_vec & OSG_USED_MASK) != 16'h0000
		|=> (event_reg & $past(set_vec) & OSG_USED_MASK) == ($past(set_vec) & OSG_USED_MASK))
		else $error("passed transition not latched");
	event_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!event_rd && set_vec == 16'h0000 |=> $stable(event_reg))
		else $error("event register moved with no cause");
	no_source_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!event_reg[OSG_TRIG_BIT] && !set_vec[OSG_TRIG_BIT] |=> !event_reg[OSG_TRIG_BIT])
		else $error("event bit set with no transition");
	read_empty_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		event_rd |=> (event_reg & ~$past(set_vec)) == 16'h0000)
		else $error("event bits survived a read");
	prev_track_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		1'b1 |=> cond_prev_reg == $past(cond_vec))
		else $error("edge history out of step");
	rise_cal_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(cond_vec[OSG_CAL_BIT]) && rise_reg[OSG_CAL_BIT] |=> event_reg[OSG_CAL_BIT])
		else $error("rising edge of calibration not latched");
	fall_trig_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$fell(cond_vec[OSG_TRIG_BIT]) && fall_reg[OSG_TRIG_BIT] |=> event_reg[OSG_TRIG_BIT])
		else $error("falling edge of trigger wait not latched");
	fall_mask_event_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		fall_wr && req.wdata[OSG_CAL_BIT] && !fall_reg[OSG_CAL_BIT] && !cond_vec[OSG_CAL_BIT]
		|=> event_reg[OSG_CAL_BIT])
		else $error("falling mask write did not raise event");
	cond_unused_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(cond_vec & ~OSG_USED_MASK) == 16'h0000)
		else $error("condition on unassigned bit");

	rise_cov_c: cover property (@(posedge sys_clk) disable iff (!resetn)
		$rose(cond_vec[OSG_TRIG_BIT]) ##1 event_reg[OSG_TRIG_BIT]);
	clear_cov_c: cover property (@(posedge sys_clk) disable iff (!resetn)
		ev_rd_d && event_reg == 16'h0000);
	summary_cov_c: cover property (@(posedge sys_clk) disable iff (!resetn)
		$rose(operation_summary_flag));
	race_cov_c: cover property (@(posedge sys_clk) disable iff (!resetn)
		event_rd && set_vec != 16'h0000);
	mask_cov_c: cover property (@(posedge sys_clk) disable iff (!resetn)
		rise_wr && (req.wdata & ~rise_reg & cond_vec) != 16'h0000);
endmodule // osg_top

// File: osg_pkg.sv
// Package: register map, field layout and reset values of the operation status group
package osg_pkg;

	localparam int OSG_DATA_W = 16;
	localparam int OSG_ADDR_W = 8;

	// Register byte addresses, one aligned word each
	localparam logic [7:0] OSG_COND_ADDR = 8'h00;
	localparam logic [7:0] OSG_RISE_ADDR = 8'h04;
	localparam logic [7:0] OSG_FALL_ADDR = 8'h08;
	localparam logic [7:0] OSG_EVENT_ADDR = 8'h0C;
	localparam logic [7:0] OSG_ENABLE_ADDR = 8'h10;
	localparam logic [7:0] OSG_STATUS_ADDR = 8'h14;

	// Condition bit positions
	localparam int OSG_CAL_BIT = 0;
	localparam int OSG_TRIG_BIT = 5;
	localparam int OSG_VREG_BIT = 8;
	localparam int OSG_IREG_BIT = 10;

	// Summary flag position in the status byte
	localparam int OSG_SUMMARY_BIT = 7;

	// Reset values
	localparam logic [15:0] OSG_RISE_RST = 16'h0000;
	localparam logic [15:0] OSG_FALL_RST = 16'h0000;
	localparam logic [15:0] OSG_ENABLE_RST = 16'h0000;
	localparam logic [15:0] OSG_EVENT_RST = 16'h0000;

	// Mask of implemented condition bits
	localparam logic [15:0] OSG_USED_MASK = 16'h0521;

	typedef struct packed {
		logic [OSG_ADDR_W-1:0] addr;
		logic [OSG_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} osg_req_t;

	typedef struct packed {
		logic calibrating;
		logic awaiting_trigger_flag;
		logic voltage_regulation_flag;
		logic current_regulation_flag;
	} osg_cond_t;

endpackage

// File: osg_sync.sv
// Two-flop synchroniser for the monitored condition inputs
`timescale 1ns/1ps
module osg_sync
#(
	parameter int W = 4
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] d_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] out_next;

	always_comb
	begin
		meta_next = d_in;
		out_next = meta_reg;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_reg <= '0;
			d_out <= '0;
		end
		else
		begin
			meta_reg <= meta_next;
			d_out <= out_next;
		end
	end
endmodule // osg_sync

// File: osg_ctrl_model.sv
// Register port master model issuing status group writes and queries
`timescale 1ns/1ps
module osg_ctrl_model
	import osg_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Request and answer
	output osg_pkg::osg_req_t req,
	input wire logic [osg_pkg::OSG_DATA_W-1:0] rdata
);
	initial req = '0;

	// Strobe lasts one cycle; address and data are left standing afterwards
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		req.rd <= 1'b0;
		#1 v = rdata;
	endtask
endmodule // osg_ctrl_model

// File: test_operation_status_group.sv
// Self-checking bench for the operation status group against an integer model
`timescale 1ns/1ps
module test_operation_status_group;
	import osg_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	osg_cond_t cond_in = '0;
	osg_req_t req;
	logic [15:0] rdata;
	logic [15:0] d;
	logic operation_summary_flag;
	logic irq;
	int fails = 0;
	int checked = 0;
	int rise = 0, fall = 0, en = 0, ev = 0, cv = 0, nv = 0;

	always #5 sys_clk = ~sys_clk;

	osg_top u_dut (.sys_clk(sys_clk), .resetn(resetn), .req(req), .rdata(rdata),
		.cond_in(cond_in), .operation_summary_flag(operation_summary_flag), .irq(irq));
	osg_ctrl_model u_ctrl (.sys_clk(sys_clk), .req(req), .rdata(rdata));

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	task automatic end_of_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic int to_vec(osg_cond_t c);
		return int'(c.calibrating) << OSG_CAL_BIT | int'(c.awaiting_trigger_flag) << OSG_TRIG_BIT
			| int'(c.voltage_regulation_flag) << OSG_VREG_BIT
			| int'(c.current_regulation_flag) << OSG_IREG_BIT;
	endfunction

	task automatic rd_chk(input logic [7:0] a, input int e);
		u_ctrl.rd(a, d);
		chk(d, e[15:0]);
	endtask

	// Newly set mask bits can latch an event from the level already present
	task automatic set_mask(input logic [7:0] a, input int v);
		if (a == OSG_RISE_ADDR)
			ev |= v & ~rise & cv;
		if (a == OSG_FALL_ADDR)
			ev |= v & ~fall & ~cv;
		if (a == OSG_RISE_ADDR)
			rise = v;
		else if (a == OSG_FALL_ADDR)
			fall = v;
		else
			en = v;
		u_ctrl.wr(a, v[15:0]);
	endtask

	initial
	begin
		void'($urandom(98));
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		// All nine word addresses, the six in the map and three past it, read zero after reset
		for (int i = 0; i < 9; i++)
			rd_chk(8'(i * 4), 0);
		u_ctrl.wr(OSG_COND_ADDR, 16'hffff);
		rd_chk(OSG_COND_ADDR, 0);
		$display("test reset and map done");
		repeat (60)
		begin
			set_mask(OSG_RISE_ADDR, $urandom & OSG_USED_MASK);
			set_mask(OSG_FALL_ADDR, $urandom & OSG_USED_MASK);
			set_mask(OSG_ENABLE_ADDR, $urandom & OSG_USED_MASK);
			rd_chk(OSG_RISE_ADDR, rise);
			rd_chk(OSG_FALL_ADDR, fall);
			rd_chk(OSG_ENABLE_ADDR, en);
			@(posedge sys_clk);
			cond_in <= osg_cond_t'(4'($urandom));
			#1 nv = to_vec(cond_in);
			ev |= rise & nv & ~cv | fall & cv & ~nv;
			cv = nv;
			// Two sync flops plus the event register
			repeat (4) @(posedge sys_clk);
			#1 chk({15'h0000, operation_summary_flag}, 16'((ev & en) != 0));
			chk({15'h0000, irq}, 16'((ev & en) != 0));
			rd_chk(OSG_COND_ADDR, cv);
			u_ctrl.rd(OSG_STATUS_ADDR, d);
			chk({15'h0000, d[OSG_SUMMARY_BIT]}, 16'((ev & en) != 0));
			if ($urandom_range(1) == 1)
			begin
				rd_chk(OSG_EVENT_ADDR, ev);
				ev = 0;
			end
		end
		rd_chk(OSG_EVENT_ADDR, ev);
		rd_chk(OSG_EVENT_ADDR, 0);
		$display("test random traffic done");
		// Reset again mid-run: registers clear while the inputs stay put
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rise = 0;
		fall = 0;
		en = 0;
		ev = 0;
		rd_chk(OSG_RISE_ADDR, 0);
		rd_chk(OSG_FALL_ADDR, 0);
		rd_chk(OSG_ENABLE_ADDR, 0);
		rd_chk(OSG_COND_ADDR, cv);
		rd_chk(OSG_EVENT_ADDR, 0);
		chk({15'h0000, irq}, 16'h0000);
		$display("test mid-run reset done");
		end_of_test();
	end

	// Traffic needs some 1,400 cycles; allow over fourteen times that
	initial
	begin
		#200us;
		fails++;
		end_of_test();
	end
endmodule // test_operation_status_group
